// File: rtl/pdcfg_regs.sv
// phase detector and exact-frequency configuration registers
// assumes a one-cycle strobe register port on the same clock
//
// Functional notes
// RL1 - three-bit reset-path delay, resets to one
// RL2 - bit 5 up output enable, resets one
// RL3 - bit 6 down output enable, resets one
// RL4 - bits 8:7 select slip prevention threshold
// RL5 - software enables slip prevention only at low rates
// RL6 - bit 9 forces charge pump up on
// RL7 - bit 10 forces charge pump down on
// RL8 - bit 11 forces charge pump mid-rail
// RL9 - bits 21:20 select divider pulse width
// RL10 - channel count zero or one disables correction
// RL11 - software picks count giving integer ratio
// RL12 - software writes reserved fields with reset values
`timescale 1ns/100ps
`default_nettype none
`include "pdcfg_map.svh"

module pdcfg_regs
  import pdcfg_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  // register port
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic [23:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [23:0] reg_rdata_out,
  // phase detector and charge pump controls
  output logic      [2:0]  detector_reset_delay_select_out,
  output logic             detector_up_output_enable_out,
  output logic             detector_down_output_enable_out,
  output pdcfg_csp_e       cycle_slip_prevention_out,
  output logic             charge_pump_force_up_out,
  output logic             charge_pump_force_down_out,
  output logic             charge_pump_force_mid_out,
  output logic      [1:0]  divider_pulse_width_out,
  // exact-frequency correction
  output logic      [13:0] exact_channel_count_out,
  output logic             exact_correction_enable_out
);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  pdcfg_word_t pd_r, pd_nxt;
  pdcfg_word_t ex_r, ex_nxt;
  pdcfg_word_t rdata_r, rdata_nxt;

  // reserved bits are stored as written so a readback matches the write
  always_comb begin
    pd_nxt    = pd_r;
    ex_nxt    = ex_r;
    rdata_nxt = 24'h00_0000;
    if (reg_wr_in && reg_addr_in == `PDCFG_OFS_PD) begin
      pd_nxt = reg_wdata_in; // RL1
    end
    if (reg_wr_in && reg_addr_in == `PDCFG_OFS_EXACT) begin
      ex_nxt = reg_wdata_in; // RL10
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        `PDCFG_OFS_PD:    rdata_nxt = pd_r;
        `PDCFG_OFS_EXACT: rdata_nxt = ex_r;
        default:          rdata_nxt = 24'h00_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      pd_r    <= `PDCFG_RST_PD; // RL1
      ex_r    <= `PDCFG_RST_EXACT;
      rdata_r <= 24'h00_0000;
    end else begin
      pd_r    <= pd_nxt;
      ex_r    <= ex_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // field outputs
  // ---------------------------------------------------------------
  assign reg_rdata_out                   = rdata_r;
  assign detector_reset_delay_select_out = pd_r[`PDCFG_DEL_MSB:`PDCFG_DEL_LSB]; // RL1
  assign detector_up_output_enable_out   = pd_r[`PDCFG_UP_EN_BIT]; // RL2
  assign detector_down_output_enable_out = pd_r[`PDCFG_DN_EN_BIT]; // RL3
  assign cycle_slip_prevention_out       =
    pdcfg_csp_e'(pd_r[`PDCFG_CSP_MSB:`PDCFG_CSP_LSB]); // RL4
  assign charge_pump_force_up_out        = pd_r[`PDCFG_FRC_UP_BIT]; // RL6
  assign charge_pump_force_down_out      = pd_r[`PDCFG_FRC_DN_BIT]; // RL7
  assign charge_pump_force_mid_out       = pd_r[`PDCFG_FRC_MID_BIT]; // RL8
  assign divider_pulse_width_out         = pd_r[`PDCFG_PW_MSB:`PDCFG_PW_LSB]; // RL9
  assign exact_channel_count_out         = ex_r[`PDCFG_CHAN_MSB:0]; // RL10
  // counts below two leave correction off
  assign exact_correction_enable_out     = (ex_r[`PDCFG_CHAN_MSB:0] >= `PDCFG_CHAN_MIN); // RL10

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence s_pd_write;
    reg_wr_in && reg_addr_in == `PDCFG_OFS_PD;
  endsequence

  a_delay_after_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_write |=> detector_reset_delay_select_out == $past(reg_wdata_in[2:0])) // RL1
    else $error("delay select not loaded");
  a_up_enable_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_write |=> detector_up_output_enable_out == $past(reg_wdata_in[5])) // RL2
    else $error("up enable not loaded");
  a_down_enable_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_write |=> detector_down_output_enable_out == $past(reg_wdata_in[6])) // RL3
    else $error("down enable not loaded");
  a_csp_mode_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_write |=> cycle_slip_prevention_out == $past(reg_wdata_in[8:7])) // RL4
    else $error("slip mode not loaded");
  a_force_up_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_write |=> charge_pump_force_up_out == $past(reg_wdata_in[9])) // RL6
    else $error("force up not loaded");
  a_force_down_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_write |=> charge_pump_force_down_out == $past(reg_wdata_in[10])) // RL7
    else $error("force down not loaded");
  a_force_mid_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_write |=> charge_pump_force_mid_out == $past(reg_wdata_in[11])) // RL8
    else $error("force mid not loaded");
  a_pulse_width_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_write |=> divider_pulse_width_out == $past(reg_wdata_in[21:20])) // RL9
    else $error("pulse width not loaded");
  a_exact_enable_rule: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    exact_correction_enable_out == (exact_channel_count_out > 14'h0001)) // RL10
    else $error("exact enable wrong");
  a_reset_defaults: assert property (@(posedge clk_sys_in)
    sys_rst_in |=> detector_reset_delay_select_out == 3'h1 && detector_up_output_enable_out
      && detector_down_output_enable_out && !charge_pump_force_up_out
      && !charge_pump_force_down_out && !charge_pump_force_mid_out
      && divider_pulse_width_out == 2'h0) // RL1
    else $error("reset defaults wrong");

  // ---------------------------------------------------------------
  // access sequences
  // ---------------------------------------------------------------
  sequence s_ex_write;
    reg_wr_in && reg_addr_in == `PDCFG_OFS_EXACT;
  endsequence

  sequence s_pd_idle;
    !(reg_wr_in && reg_addr_in == `PDCFG_OFS_PD);
  endsequence

  sequence s_ex_idle;
    !(reg_wr_in && reg_addr_in == `PDCFG_OFS_EXACT);
  endsequence

  sequence s_pd_read;
    reg_rd_in && reg_addr_in == `PDCFG_OFS_PD;
  endsequence

  sequence s_ex_read;
    reg_rd_in && reg_addr_in == `PDCFG_OFS_EXACT;
  endsequence

  sequence s_no_read;
    !reg_rd_in;
  endsequence

  sequence s_other_read;
    reg_rd_in && reg_addr_in != `PDCFG_OFS_PD && reg_addr_in != `PDCFG_OFS_EXACT;
  endsequence

  sequence s_other_write;
    reg_wr_in && reg_addr_in != `PDCFG_OFS_PD && reg_addr_in != `PDCFG_OFS_EXACT;
  endsequence

  // ---------------------------------------------------------------
  // fields hold without a write
  // ---------------------------------------------------------------
  // a glitching control would upset the analog loop, so nothing but a write or reset moves it
  a_delay_holds_idle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_idle |=> $stable(detector_reset_delay_select_out)) // RL1
    else $error("delay select moved without write");
  a_up_holds_idle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_idle |=> $stable(detector_up_output_enable_out)) // RL2
    else $error("up enable moved without write");
  a_down_holds_idle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_idle |=> $stable(detector_down_output_enable_out)) // RL3
    else $error("down enable moved without write");
  a_csp_holds_idle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_idle |=> $stable(cycle_slip_prevention_out)) // RL4
    else $error("slip mode moved without write");
  a_fup_holds_idle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_idle |=> $stable(charge_pump_force_up_out)) // RL6
    else $error("force up moved without write");
  a_fdn_holds_idle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_idle |=> $stable(charge_pump_force_down_out)) // RL7
    else $error("force down moved without write");
  a_fmid_holds_idle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_idle |=> $stable(charge_pump_force_mid_out)) // RL8
    else $error("force mid moved without write");
  a_width_holds_idle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_idle |=> $stable(divider_pulse_width_out)) // RL9
    else $error("pulse width moved without write");
  a_count_holds_idle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_ex_idle |=> $stable(exact_channel_count_out)) // RL10
    else $error("channel count moved without write");

  // ---------------------------------------------------------------
  // exact-frequency register
  // ---------------------------------------------------------------
  a_count_after_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_ex_write |=> exact_channel_count_out == $past(reg_wdata_in[13:0])) // RL10
    else $error("channel count not loaded");
  a_enable_after_write: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_ex_write |=> exact_correction_enable_out == ($past(reg_wdata_in[13:0]) > 14'h0001)) // RL10
    else $error("correction enable not following write");
  a_exact_reset_off: assert property (@(posedge clk_sys_in)
    sys_rst_in |=> exact_channel_count_out == 14'h0000 && !exact_correction_enable_out) // RL10
    else $error("exact register not cleared by reset");
  a_csp_reset_off: assert property (@(posedge clk_sys_in)
    sys_rst_in |=> cycle_slip_prevention_out == PDCFG_CSP_OFF) // RL4
    else $error("slip prevention not off after reset");

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read data is a single-cycle pulse; zero otherwise keeps a wired-or bus simple
  a_read_pd_word: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_read |=> reg_rdata_out == $past(pd_r)) // RL1
    else $error("detector readback wrong");
  a_read_ex_word: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_ex_read |=> reg_rdata_out == $past(ex_r)) // RL10
    else $error("exact readback wrong");
  a_read_idle_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_no_read |=> reg_rdata_out == 24'h00_0000) // RL1
    else $error("read data not zero when idle");
  a_read_other_zero: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_other_read |=> reg_rdata_out == 24'h00_0000) // RL10
    else $error("unmapped read not zero");
  a_read_reset_zero: assert property (@(posedge clk_sys_in)
    sys_rst_in |=> reg_rdata_out == 24'h00_0000) // RL1
    else $error("read data not cleared by reset");
  a_read_one_cycle: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_pd_read ##1 s_no_read |=> reg_rdata_out == 24'h00_0000) // RL1
    else $error("read data held too long");

  // ---------------------------------------------------------------
  // unmapped writes and reads leave state alone
  // ---------------------------------------------------------------
  a_unmapped_pd_keep: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_other_write |=> $stable(pd_r)) // RL1
    else $error("unmapped write hit detector register");
  a_unmapped_ex_keep: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    s_other_write |=> $stable(ex_r)) // RL10
    else $error("unmapped write hit exact register");
  a_read_keeps_pd: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (reg_rd_in && !reg_wr_in) |=> $stable(pd_r) && $stable(ex_r)) // RL1
    else $error("read disturbed a register");

  // ---------------------------------------------------------------
  // every bit is stored, reserved ones too
  // ---------------------------------------------------------------
  // reserved bits are kept as written; software must write their defaults back
  for (genvar gi = 0; gi < 24; gi++) begin : g_bit_store
    a_pd_bit_store: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      s_pd_write |=> pd_r[gi] == $past(reg_wdata_in[gi])) // RL1
      else $error("detector bit not stored");
    a_ex_bit_store: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
      s_ex_write |=> ex_r[gi] == $past(reg_wdata_in[gi])) // RL10
      else $error("exact bit not stored");
  end

endmodule
`default_nettype wire

// File: rtl/pdcfg_map.svh
// register map constants for the phase detector configuration bank
// assumes inclusion by the bank module only
`ifndef PDCFG_MAP_SVH
`define PDCFG_MAP_SVH
// ---------------------------------------------------------------
// offsets and resets
// ---------------------------------------------------------------
`define PDCFG_OFS_PD      5'h0b
`define PDCFG_OFS_EXACT   5'h0c
`define PDCFG_RST_PD      24'h0f_8061
`define PDCFG_RST_EXACT   24'h00_0000
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PDCFG_DEL_LSB     0
`define PDCFG_DEL_MSB     2
`define PDCFG_UP_EN_BIT   5
`define PDCFG_DN_EN_BIT   6
`define PDCFG_CSP_LSB     7
`define PDCFG_CSP_MSB     8
`define PDCFG_FRC_UP_BIT  9
`define PDCFG_FRC_DN_BIT  10
`define PDCFG_FRC_MID_BIT 11
`define PDCFG_PW_LSB      20
`define PDCFG_PW_MSB      21
`define PDCFG_CHAN_MSB    13
`define PDCFG_CHAN_MIN    14'h0002
`endif

// File: rtl/pdcfg_pkg.sv
// types for the phase detector configuration bank
// assumes nothing of its surroundings
package pdcfg_pkg;
  typedef logic [23:0] pdcfg_word_t;
  typedef enum logic [1:0] {
    PDCFG_CSP_OFF  = 2'h0,
    PDCFG_CSP_NEAR = 2'h1,
    PDCFG_CSP_MID  = 2'h2,
    PDCFG_CSP_FAR  = 2'h3
  } pdcfg_csp_e;
endpackage

// File: tb/tb_top.sv
// bench for the detector and exact-frequency configuration registers
// assumes pdcfg_pkg and pdcfg_regs are compiled first; one 50 MHz clock
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pdcfg_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [4:0]  ad         = 5'h00;
  logic [23:0] wd         = 24'h00_0000;
  logic [23:0] rdat, q;
  logic [2:0]  del;
  logic        up, dn, fu, fd, fm, en;
  pdcfg_csp_e  cycle_slip_prevention;
  logic [1:0]  pw;
  logic [13:0] cnt;
  int          fails      = 0;
  int          compares   = 0;
  // rows: address beside the word written; every csp code and pulse width appears
  logic [28:0] rows [10] = '{{5'h0b, 24'h00_0000}, {5'h0b, 24'hff_ffff}, {5'h0b, 24'h10_0085},
    {5'h0b, 24'h20_0320}, {5'h0b, 24'h00_0c40}, {5'h0c, 24'h00_0000}, {5'h0c, 24'h00_0001},
    {5'h0c, 24'h00_0002}, {5'h0c, 24'h00_3fff}, {5'h0c, 24'hff_c001}};
  always #10 clk_sys_in = ~clk_sys_in;
  pdcfg_regs i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .reg_addr_in(ad),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
    .detector_reset_delay_select_out(del), .detector_up_output_enable_out(up),
    .detector_down_output_enable_out(dn), .cycle_slip_prevention_out(cycle_slip_prevention),
    .charge_pump_force_up_out(fu), .charge_pump_force_down_out(fd),
    .charge_pump_force_mid_out(fm), .divider_pulse_width_out(pw),
    .exact_channel_count_out(cnt), .exact_correction_enable_out(en));
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // strobe tasks start right after a rising edge and end on one
  task automatic wr_reg(input logic [4:0] a, input logic [23:0] d);
    wr <= 1'b1;
    ad <= a;
    wd <= d;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a);
    rd <= 1'b1;
    ad <= a;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    @(negedge clk_sys_in);
    q = rdat;
    @(posedge clk_sys_in);
  endtask
  task automatic fld(input logic [23:0] d);
    chk(24'(del), 24'(d[2:0]));
    chk(24'(up), 24'(d[5]));
    chk(24'(dn), 24'(d[6]));
    chk(24'(cycle_slip_prevention), 24'(d[8:7]));
    chk(24'(fu), 24'(d[9]));
    chk(24'(fd), 24'(d[10]));
    chk(24'(fm), 24'(d[11]));
    chk(24'(pw), 24'(d[21:20]));
  endtask
  task automatic print_verdict;
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd_reg(5'h0b);
    chk(q, 24'h0f_8061);
    fld(24'h0f_8061);
    rd_reg(5'h0c);
    chk(q, 24'h00_0000);
    chk(24'(en), 24'h00_0000);
    foreach (rows[i]) begin
      wr_reg(rows[i][28:24], rows[i][23:0]);
      rd_reg(rows[i][28:24]);
      chk(q, rows[i][23:0]);
      if (rows[i][28:24] == 5'h0b) begin
        fld(rows[i][23:0]);
      end else begin
        chk(24'(cnt), 24'(rows[i][13:0]));
        chk(24'(en), 24'(rows[i][13:0] > 14'h0001));
      end
    end
    // read data must drop back to zero, and unmapped writes must not alias
    @(negedge clk_sys_in);
    chk(rdat, 24'h00_0000);
    @(posedge clk_sys_in);
    wr_reg(5'h0d, 24'hff_ffff);
    rd_reg(5'h0d);
    chk(q, 24'h00_0000);
    rd_reg(5'h0c);
    chk(q, 24'hff_c001);
    // read then write of one register back to back returns the old word
    rd <= 1'b1;
    ad <= 5'h0b;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    wr <= 1'b1;
    wd <= 24'h0f_80e1;
    @(negedge clk_sys_in);
    chk(rdat, 24'h00_0c40);
    @(posedge clk_sys_in);
    wr <= 1'b0;
    rd_reg(5'h0b);
    fld(24'h0f_80e1);
    sys_rst_in <= 1'b1;
    @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rd_reg(5'h0b);
    chk(q, 24'h0f_8061);
    rd_reg(5'h0c);
    chk(q, 24'h00_0000);
    print_verdict;
  end
  initial begin
    #100000;
    fails++;
    print_verdict;
  end
endmodule
`default_nettype wire
